/* src/lqm_regs.sv */
// lqm_regs: link quality monitor register bank with threshold store,
// parameter sampling, warnings, interrupt re-arm and automatic DSP restart
// assumes one 250 MHz management clock; DSP parameter inputs are synchronous
`timescale 1ns/1ps

module lqm_regs
    import lqm_pkg::*;
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // DSP side
    input  lqm_dsp_t         dsp,
    output logic             dsp_restart,
    output logic             link_status_drop,
    output logic [15:0]      time_ctrl,
    // interrupt
    output logic             irq
);

    lqm_req_t                      req;
    logic [15:0]                   rdata;
    logic [NUM_THR-1:0][7:0]       thr_reg;
    logic [MON1_WARN_W:0]          viol;
    logic [MON1_WARN_W:0]          viol_d_reg;
    logic [MON1_WARN_W:0]          viol_rise;
    logic                          sample_en_reg;
    logic [2:0]                    psel_reg;
    logic                          tsel_reg;
    logic [7:0]                    tdata_reg;
    logic [7:0]                    sample_reg;
    logic [2:0]                    page_reg;
    logic                          mon_en_reg;
    logic [MON1_WARN_W-1:0]        warn_reg;
    logic                          restart_en_reg;
    logic                          var_warn_reg;
    logic                          armed_reg;
    logic                          armed_next;
    logic                          lq_int_en_reg;
    logic                          sd_opt_reg;
    logic [15:0]                   time_ctrl_reg;
    logic [IRQ_W-1:0]              irq_stat_reg;
    logic [IRQ_W-1:0]              irq_mask_reg;
    logic [IRQ_W-1:0]              irq_set;
    logic                          dsp_restart_reg;
    logic                          link_drop_reg;

    // threshold index from parameter and low/high select
    function automatic logic [3:0] thr_index(input logic [2:0] p,
                                             input logic t);
        thr_index = {p, t};
    endfunction

    // paged register decode honours the current page; page, interrupt and sublayer registers decode on every page
    function automatic logic hit(input logic [7:0] i, input logic [7:0] r,
                                 input logic [2:0] pg, input logic [2:0] want);
        hit = (i == r) && (pg == want);
    endfunction

    lqm_ahb u_ahb (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hwdata    (hwdata),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .req       (req),
        .rdata     (rdata)
    );

    lqm_thr_check u_chk (
        .hclk    (hclk),
        .hresetn (hresetn),
        .thr     (thr_reg),
        .dsp     (dsp),
        .viol    (viol)
    );

    wire wr_data  = req.wr && hit(req.idx, IDX_DATA, page_reg, PAGE_QUAL);
    wire wr_mon1  = req.wr && hit(req.idx, IDX_MON1, page_reg, PAGE_QUAL);
    wire wr_mon2  = req.wr && hit(req.idx, IDX_MON2, page_reg, PAGE_QUAL);
    wire rd_mon1  = req.rd && hit(req.idx, IDX_MON1, page_reg, PAGE_QUAL);
    wire rd_mon2  = req.rd && hit(req.idx, IDX_MON2, page_reg, PAGE_QUAL);
    wire wr_time  = req.wr && hit(req.idx, IDX_TIME_CTRL, page_reg, PAGE_TIME);
    wire wr_page  = req.wr && req.idx == IDX_PAGE;
    wire wr_intc  = req.wr && req.idx == IDX_INT_CTRL;
    wire wr_subl  = req.wr && req.idx == IDX_SUBLAYER;
    wire wr_istat = req.wr && req.idx == IDX_IRQ_STAT;
    wire wr_imask = req.wr && req.idx == IDX_IRQ_MASK;
    wire wr_thr   = wr_data && req.wdata[DATA_WSTB_BIT]
                    && !req.wdata[DATA_SAMPLE_BIT];
    wire [3:0] wsel = thr_index(req.wdata[DATA_PSEL_LSB +: 3],
                                req.wdata[DATA_TSEL_BIT]);
    wire [3:0] rsel = thr_index(psel_reg, tsel_reg);

    // data register fields
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sample_en_reg <= 1'b0;
            psel_reg      <= 3'h0;
            tsel_reg      <= 1'b0;
            tdata_reg     <= THR_RESET;
        end
        else if (wr_data)
        begin
            sample_en_reg <= req.wdata[DATA_SAMPLE_BIT];
            psel_reg      <= req.wdata[DATA_PSEL_LSB +: 3];
            tsel_reg      <= req.wdata[DATA_TSEL_BIT];
            tdata_reg     <= req.wdata[7:0];
        end
    end

    // threshold store; codes beyond the last threshold are dropped
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            thr_reg <= {NUM_THR{THR_RESET}};
        else if (wr_thr && wsel < 4'(NUM_THR))
            thr_reg[wsel] <= req.wdata[7:0];
    end

    // parameter value taken when a write sets the sample bit
    function automatic logic [7:0] live_param(input lqm_dsp_t d,
                                              input logic [2:0] p,
                                              input logic t);
        unique case (p)
            3'h0:      live_param = d.c1;
            3'h1:      live_param = d.agc;
            3'h2:      live_param = d.blw;
            PSEL_FOFF: live_param = d.foff;
            PSEL_FCTL: live_param = d.fctl;
            PSEL_VAR:  live_param = t ? d.variance[31:24] : d.variance[23:16];
            default:   live_param = 8'h00;
        endcase
    endfunction

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            sample_reg <= 8'h00;
        else if (wr_data && req.wdata[DATA_SAMPLE_BIT])
            sample_reg <= live_param(dsp, req.wdata[DATA_PSEL_LSB +: 3],
                                     req.wdata[DATA_TSEL_BIT]);
    end

    // page, interrupt control, sublayer option and time protocol page
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            page_reg      <= 3'h0;
            lq_int_en_reg <= 1'b0;
            sd_opt_reg    <= 1'b0;
            time_ctrl_reg <= 16'h0000;
        end
        else
        begin
            if (wr_page)
                page_reg <= req.wdata[2:0];
            if (wr_intc)
                lq_int_en_reg <= req.wdata[INTC_LQ_EN_BIT];
            if (wr_subl)
                sd_opt_reg <= req.wdata[SUBL_SDOPT_BIT];
            if (wr_time)
                time_ctrl_reg <= req.wdata & TIME_CTRL_MASK;
        end
    end

    // violation edges; a level violation raises one event only
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            viol_d_reg <= '0;
        else
            viol_d_reg <= viol;
    end
    assign viol_rise = viol & ~viol_d_reg & {(MON1_WARN_W + 1){mon_en_reg}};

    // monitor 1: enable and sticky warnings, cleared on read
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mon_en_reg <= 1'b0;
            warn_reg   <= '0;
        end
        else
        begin
            if (wr_mon1)
                mon_en_reg <= req.wdata[MON1_EN_BIT];
            warn_reg <= (rd_mon1 ? '0 : warn_reg)
                        | viol_rise[MON1_WARN_W-1:0];
        end
    end

    // monitor 2: restart control and variance warning
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            restart_en_reg <= 1'b0;
            var_warn_reg   <= 1'b0;
        end
        else
        begin
            if (wr_mon2)
                restart_en_reg <= req.wdata[MON2_RESTART_BIT];
            // set wins over clear-on-read
            var_warn_reg <= (var_warn_reg && !rd_mon2)
                            || viol_rise[MON1_WARN_W];
        end
    end

    // arming: events disarm, only a monitor 1 read re-arms
    wire lq_event = armed_reg && lq_int_en_reg && (|viol_rise);
    assign armed_next = (armed_reg && !lq_event) || rd_mon1;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            armed_reg <= 1'b1;
        else
            armed_reg <= armed_next;
    end

    // automatic restart on a frequency offset violation
    wire foff_rise = |viol_rise[2*PSEL_FOFF +: 2];
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dsp_restart_reg <= 1'b0;
            link_drop_reg   <= 1'b0;
        end
        else
        begin
            dsp_restart_reg <= foff_rise && restart_en_reg;
            link_drop_reg   <= foff_rise && restart_en_reg
                               && !sd_opt_reg;
        end
    end

    // sticky interrupt status, write one to clear, set wins
    assign irq_set = {dsp_restart_reg, lq_event};
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_stat_reg <= '0;
            irq_mask_reg <= '0;
        end
        else
        begin
            irq_stat_reg <= (irq_stat_reg & ~(wr_istat ? req.wdata[IRQ_W-1:0]
                            : '0)) | irq_set;
            if (wr_imask)
                irq_mask_reg <= req.wdata[IRQ_W-1:0];
        end
    end

    // read mux; reserved bits and the strobe read as zero
    always_comb
    begin
        rdata = 16'h0000;
        if (req.idx == IDX_PAGE)
            rdata[2:0] = page_reg;
        else if (req.idx == IDX_INT_CTRL)
            rdata[INTC_LQ_EN_BIT] = lq_int_en_reg;
        else if (req.idx == IDX_SUBLAYER)
            rdata[SUBL_SDOPT_BIT] = sd_opt_reg;
        else if (req.idx == IDX_IRQ_STAT)
            rdata[IRQ_W-1:0] = irq_stat_reg;
        else if (req.idx == IDX_IRQ_MASK)
            rdata[IRQ_W-1:0] = irq_mask_reg;
        else if (hit(req.idx, IDX_TIME_CTRL, page_reg, PAGE_TIME))
            rdata = time_ctrl_reg;
        else if (hit(req.idx, IDX_MON1, page_reg, PAGE_QUAL))
        begin
            rdata[MON1_EN_BIT] = mon_en_reg;
            rdata[MON1_WARN_W-1:0] = warn_reg;
        end
        else if (hit(req.idx, IDX_MON2, page_reg, PAGE_QUAL))
        begin
            rdata[MON2_RESTART_BIT] = restart_en_reg;
            rdata[MON2_VARWARN_BIT] = var_warn_reg;
        end
        else if (hit(req.idx, IDX_DATA, page_reg, PAGE_QUAL))
        begin
            rdata[DATA_SAMPLE_BIT] = sample_en_reg;
            rdata[DATA_PSEL_LSB +: 3] = psel_reg;
            rdata[DATA_TSEL_BIT] = tsel_reg;
            // unused codes read the reset value
            rdata[7:0] = sample_en_reg ? sample_reg
                       : (rsel < 4'(NUM_THR) ? thr_reg[rsel]
                       : THR_RESET);
        end
    end

    assign dsp_restart      = dsp_restart_reg;
    assign link_status_drop = link_drop_reg;
    assign time_ctrl        = time_ctrl_reg;
    assign irq              = |(irq_stat_reg & irq_mask_reg);

    // checks
    wire rd_data = req.rd && hit(req.idx, IDX_DATA, page_reg, PAGE_QUAL);

    sequence s_foff_hit;
        foff_rise && restart_en_reg;
    endsequence

    property p_wstb_zero;
        @(posedge hclk) disable iff (!hresetn)
        rd_data |-> !rdata[DATA_WSTB_BIT];
    endproperty
    a_wstb_zero: assert property (p_wstb_zero)
        else $error("write strobe read back as one");

    property p_thr_store;
        @(posedge hclk) disable iff (!hresetn)
        (wr_thr && wsel < 4'(NUM_THR)) |=> thr_reg[$past(wsel)]
            == $past(req.wdata[7:0]);
    endproperty
    a_thr_store: assert property (p_thr_store)
        else $error("threshold not stored on strobe write");

    property p_thr_read;
        @(posedge hclk) disable iff (!hresetn)
        (rd_data && !sample_en_reg && rsel < 4'(NUM_THR))
            |=> hrdata[7:0] == $past(thr_reg[rsel]);
    endproperty
    a_thr_read: assert property (p_thr_read)
        else $error("threshold read back wrong");

    property p_sample_hold;
        @(posedge hclk) disable iff (!hresetn)
        (sample_en_reg && !wr_data) |=> $stable(sample_reg);
    endproperty
    a_sample_hold: assert property (p_sample_hold)
        else $error("sampled value changed without resample");

    property p_irq_raise;
        @(posedge hclk) disable iff (!hresetn)
        (armed_reg && lq_int_en_reg && |viol_rise) |=> irq_stat_reg[IRQ_LQ];
    endproperty
    a_irq_raise: assert property (p_irq_raise)
        else $error("violation did not set interrupt status");

    property p_mon2_noarm;
        @(posedge hclk) disable iff (!hresetn)
        (rd_mon2 && !rd_mon1 && !armed_reg) |=> !armed_reg;
    endproperty
    a_mon2_noarm: assert property (p_mon2_noarm)
        else $error("monitor 2 read re-armed interrupts");

    property p_rearm;
        @(posedge hclk) disable iff (!hresetn)
        rd_mon1 |=> armed_reg;
    endproperty
    a_rearm: assert property (p_rearm)
        else $error("monitor 1 read did not re-arm");

    property p_restart;
        @(posedge hclk) disable iff (!hresetn)
        s_foff_hit |=> dsp_restart ##1 !dsp_restart || $past(foff_rise);
    endproperty
    a_restart: assert property (p_restart)
        else $error("no DSP restart after offset violation");

    property p_link_drop;
        @(posedge hclk) disable iff (!hresetn)
        s_foff_hit |=> link_status_drop == !$past(sd_opt_reg);
    endproperty
    a_link_drop: assert property (p_link_drop)
        else $error("link drop disagrees with signal-detect option");

    property p_var_warn;
        @(posedge hclk) disable iff (!hresetn)
        viol_rise[MON1_WARN_W] |=> var_warn_reg;
    endproperty
    a_var_warn: assert property (p_var_warn)
        else $error("variance warning not set");

    property p_mon2_rsv;
        @(posedge hclk) disable iff (!hresetn)
        rd_mon2 |=> (hrdata[15:0] & ~16'h0402) == 16'h0000;
    endproperty
    a_mon2_rsv: assert property (p_mon2_rsv)
        else $error("monitor 2 reserved bits nonzero");

    property p_page;
        @(posedge hclk) disable iff (!hresetn)
        (page_reg != PAGE_TIME) |=> $stable(time_ctrl_reg);
    endproperty
    a_page: assert property (p_page)
        else $error("time page written off its page");

endmodule

/* src/lqm_pkg.sv */
// lqm_pkg: constants and carrier types of the link quality monitor registers
// assumes a word-wide AHB-Lite register bus; index = byte address / 4
package lqm_pkg;

    // register indices (byte address is four times the index)
    localparam logic [7:0] IDX_INT_CTRL  = 8'h12;
    localparam logic [7:0] IDX_PAGE      = 8'h13;
    localparam logic [7:0] IDX_TIME_CTRL = 8'h14;
    localparam logic [7:0] IDX_SUBLAYER  = 8'h16;
    localparam logic [7:0] IDX_MON1      = 8'h1C;
    localparam logic [7:0] IDX_MON2      = 8'h1D;
    localparam logic [7:0] IDX_DATA      = 8'h1E;
    localparam logic [7:0] IDX_IRQ_STAT  = 8'h30;
    localparam logic [7:0] IDX_IRQ_MASK  = 8'h31;

    // page numbers
    localparam logic [2:0] PAGE_QUAL = 3'h2;
    localparam logic [2:0] PAGE_TIME = 3'h4;

    // data register fields
    localparam int DATA_SAMPLE_BIT = 13;
    localparam int DATA_WSTB_BIT   = 12;
    localparam int DATA_PSEL_LSB   = 9;
    localparam int DATA_TSEL_BIT   = 8;
    localparam logic [7:0] THR_RESET = 8'h80;

    // parameter select codes
    localparam logic [2:0] PSEL_FOFF = 3'h3;
    localparam logic [2:0] PSEL_FCTL = 3'h4;
    localparam logic [2:0] PSEL_VAR  = 3'h5;
    localparam int         NUM_THR   = 12;

    // monitor / control fields
    localparam int MON1_EN_BIT      = 15;
    localparam int MON1_WARN_W      = 10;
    localparam int MON2_RESTART_BIT = 10;
    localparam int MON2_VARWARN_BIT = 1;
    localparam int SUBL_SDOPT_BIT   = 8;
    localparam int INTC_LQ_EN_BIT   = 0;
    localparam logic [15:0] TIME_CTRL_MASK = 16'h1FFF;

    // sticky interrupt status bits
    localparam int IRQ_LQ  = 0;
    localparam int IRQ_RST = 1;
    localparam int IRQ_W   = 2;

    // live DSP parameters seen by the monitor
    typedef struct packed {
        logic [31:0] variance;
        logic [7:0]  fctl;
        logic [7:0]  foff;
        logic [7:0]  blw;
        logic [7:0]  agc;
        logic [7:0]  c1;
    } lqm_dsp_t;

    // one register access, valid for a single cycle
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  idx;
        logic [15:0] wdata;
    } lqm_req_t;

endpackage

/* src/lqm_ahb.sv */
// lqm_ahb: AHB-Lite slave front end, one wait state on every transfer
// assumes single word transfers; the register file answers within a cycle
`timescale 1ns/1ps
module lqm_ahb
    import lqm_pkg::*;
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // register file side
    output lqm_req_t         req,
    input  wire logic [15:0] rdata
);

    logic       busy_reg;
    logic       wr_reg;
    logic [7:0] idx_reg;
    logic [31:0] hrdata_reg;

    wire accept = hsel && htrans[1] && hready;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            busy_reg <= 1'b0;
            wr_reg   <= 1'b0;
            idx_reg  <= 8'h00;
        end
        else
        begin
            busy_reg <= accept;
            if (accept)
            begin
                wr_reg  <= hwrite;
                idx_reg <= haddr[9:2];
            end
        end
    end

    // read data caught in the wait cycle so hrdata comes from a flop
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata_reg <= 32'h0000_0000;
        else if (busy_reg && !wr_reg)
            hrdata_reg <= {16'h0000, rdata};
    end

    assign req.wr    = busy_reg && wr_reg;
    assign req.rd    = busy_reg && !wr_reg;
    assign req.idx   = idx_reg;
    assign req.wdata = hwdata[15:0];
    assign hreadyout = !busy_reg;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_reg;

endmodule

/* src/lqm_thr_check.sv */
// lqm_thr_check: compares live DSP parameters against the thresholds
// assumes thresholds ordered {param, low/high}; outputs are registered
`timescale 1ns/1ps
module lqm_thr_check
    import lqm_pkg::*;
(
    // clock and reset
    input  wire logic                       hclk,
    input  wire logic                       hresetn,
    // inputs
    input  wire logic [NUM_THR-1:0][7:0]    thr,
    input  lqm_dsp_t                        dsp,
    // violations: [9:0] low/high of params 0..4, [10] variance high
    output logic [MON1_WARN_W:0]            viol
);

    // 1 when value leaves the band [lo, hi]
    function automatic logic [1:0] band(input logic [7:0] v,
                                        input logic [7:0] lo,
                                        input logic [7:0] hi);
        band = {v > hi, v < lo};
    endfunction

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            viol <= '0;
        else
        begin
            viol[1:0] <= band(dsp.c1,   thr[0], thr[1]);
            viol[3:2] <= band(dsp.agc,  thr[2], thr[3]);
            viol[5:4] <= band(dsp.blw,  thr[4], thr[5]);
            viol[7:6] <= band(dsp.foff, thr[6], thr[7]);
            viol[9:8] <= band(dsp.fctl, thr[8], thr[9]);
            // variance has only a high limit, bits 31:16
            viol[MON1_WARN_W] <= dsp.variance[31:16] > {thr[11], thr[10]};
        end
    end

endmodule

/* dv/lqm_regs_tb.sv */
// lqm_regs_tb: self-checking bench for the quality monitor registers
// assumes the bench is sole AHB-Lite master; hready loops from hreadyout
`timescale 1ns/1ps
module lqm_regs_tb;
    import lqm_pkg::*;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd_val;
    logic        hreadyout, hresp, dsp_restart, link_status_drop, irq;
    logic [15:0] time_ctrl;
    lqm_dsp_t    dsp = '{32'h8080_0000, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80};
    int          miscompares = 0, comparisons = 0, n_rst = 0, n_drop = 0;
    logic [7:0]  thr_val [4] = '{8'h70, 8'h90, 8'h00, 8'h85};
    lqm_regs u_lqm_regs (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .dsp(dsp), .dsp_restart(dsp_restart),
        .link_status_drop(link_status_drop), .time_ctrl(time_ctrl), .irq(irq));
    always #2 hclk = ~hclk;
    always @(posedge hclk)
    begin
        if (dsp_restart === 1'b1) n_rst++;
        if (link_status_drop === 1'b1) n_drop++;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one single transfer; waits on hready, takes read data at data end
    task automatic xfer(input logic wr, input logic [7:0] idx,
                        input logic [15:0] d);
        @(posedge hclk);
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= wr;
        haddr <= {22'h0, idx, 2'h0};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0; hsel <= 1'b0; hwdata <= {16'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_val = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [15:0] exp);
        xfer(1'b0, idx, 16'h0);
        chk(rd_val, {16'h0, exp});
    endtask
    task automatic settle(input logic [7:0] foff);
        @(posedge hclk);
        dsp.foff <= foff;
        repeat (8) @(posedge hclk);
    endtask
    task automatic report_and_stop;
        if (miscompares == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic t_thresholds;
        xfer(1'b1, IDX_PAGE, 16'h2);
        rd_chk(IDX_DATA, 16'h0080);
        for (int i = 0; i < 4; i++)
        begin
            logic [3:0] f;
            f = {3'(4 + i / 2), 1'(i % 2)};
            xfer(1'b1, IDX_DATA, {4'h1, f, thr_val[i]});
            rd_chk(IDX_DATA, {4'h0, f, thr_val[i]});
            xfer(1'b1, IDX_DATA, {4'h0, f, 8'h0});
            rd_chk(IDX_DATA, {4'h0, f, thr_val[i]});
        end
    endtask
    task automatic t_sample;
        xfer(1'b1, IDX_DATA, 16'h2B00);
        rd_chk(IDX_DATA, 16'h2B80);
        @(posedge hclk);
        dsp.variance <= 32'h8100_0000;
        rd_chk(IDX_DATA, 16'h2B80);
        xfer(1'b1, IDX_DATA, 16'h0);
    endtask
    task automatic t_monitor;
        xfer(1'b1, IDX_INT_CTRL, 16'h1);
        xfer(1'b1, IDX_IRQ_MASK, 16'h3);
        xfer(1'b1, IDX_SUBLAYER, 16'h0);
        xfer(1'b1, IDX_MON2, 16'hFFFF);
        rd_chk(IDX_MON2, 16'h0400);
        xfer(1'b1, IDX_MON1, 16'h8000);
        settle(8'h90);
        chk(irq, 1'b1);
        chk(n_rst, 1);
        chk(n_drop, 1);
        rd_chk(IDX_IRQ_STAT, 16'h0003);
        rd_val = 32'h0;
        xfer(1'b0, IDX_MON2, 16'h0);
        xfer(1'b1, IDX_IRQ_STAT, 16'h3);
        chk(irq, 1'b0);
        // restart events keep coming; mask them so irq shows only arming
        xfer(1'b1, IDX_IRQ_MASK, 16'h1);
        xfer(1'b1, IDX_SUBLAYER, 16'h0100);
        settle(8'h80);
        settle(8'h90);
        chk(irq, 1'b0);
        xfer(1'b1, IDX_IRQ_STAT, 16'h3);
        rd_chk(IDX_MON1, 16'h8080);
        settle(8'h80);
        settle(8'h90);
        chk(irq, 1'b1);
        @(posedge hclk);
        dsp.variance <= 32'h9000_0000;
        repeat (8) @(posedge hclk);
        rd_chk(IDX_MON2, 16'h0402);
        rd_chk(IDX_MON2, 16'h0400);
        chk(n_rst, 3);
        chk(n_drop, 1);
    endtask
    task automatic t_page;
        xfer(1'b1, IDX_PAGE, 16'h4);
        xfer(1'b1, IDX_TIME_CTRL, 16'hFFFF);
        chk(time_ctrl, 16'h1FFF);
        rd_chk(IDX_DATA, 16'h0);
        rd_chk(8'h3F, 16'h0);
    endtask
    initial
    begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        t_thresholds();
        t_sample();
        t_monitor();
        t_page();
        report_and_stop();
    end
    // whole run is a few hundred cycles; this bound only cuts a hang
    initial
    begin
        #20000;
        miscompares++;
        report_and_stop();
    end
endmodule
